// ===== verilog/lfd_cycle_decode.v
// Preamble decoder of the low-pin-count flash bus peripheral
`timescale 1ns/100ps
`include "lfd_map.vh"
module lfd_cycle_decode #(
	parameter WAKE_CYCLES = `LFD_WAKE_CYCLES,
	parameter SECTORS = 8
) (
	input wire sys_clk_in, // Bus clock
	input wire rst_n_in, // Reset, active low
	input wire init_n_in, // Second reset, active low
	input wire frame_strobe_n_in, // Frame strobe, active low
	input wire [3:0] muxed_nibble_lines_in, // Bus nibble in
	input wire [3:0] id_strap_pins_in, // Strapped device id
	input wire drive_req_in, // Later phases want to drive
	input wire [3:0] drive_data_in, // Nibble for later phases
	input wire op_busy_in, // Program or erase running
	input wire unlock_in, // Pulse: unlock sector
	input wire [2:0] unlock_sector_in, // Sector to unlock
	output reg [3:0] muxed_nibble_lines_out, // Bus nibble out
	output reg muxed_nibble_lines_oe_n_out, // Low while driving
	output reg cycle_valid_out, // Pulse: preamble accepted
	output reg cycle_write_out, // Direction of accepted cycle
	output reg [27:0] memory_address_field_out, // Assembled address
	output reg size_error_out, // Pulse: size not one byte
	output reg standby_out, // Not selected, idle power
	output reg read_array_mode_out, // Array reads active
	output reg op_abort_out, // Reset hit a running operation
	output reg cmd_write_ok_out, // Command writes accepted
	output reg [SECTORS-1:0] sector_locked_out // Sector locks
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_IDLE = 5'h01;
	localparam ST_SEL = 5'h02;
	localparam ST_ADDR = 5'h04;
	localparam ST_SIZE = 5'h08;
	localparam ST_SKIP = 5'h10;

	// ----------------------------------------
	// Decoder registers and internal nets
	// ----------------------------------------
	// One-hot state; nib_cnt_r counts address nibbles taken
	reg [4:0] state_r, state_nxt;
	reg [2:0] nib_cnt_r, nib_cnt_nxt;
	reg write_r, write_nxt;
	reg [27:0] addr_r, addr_nxt;
	reg busy_seen_r;
	wire rst_all_n;
	wire wake_ok;
	wire [SECTORS-1:0] locks;

	// ----------------------------------------
	// Reset combine
	// ----------------------------------------
	// Either reset input resets everything but busy_seen_r and op_abort_out, which follow rst_n_in alone
	assign rst_all_n = rst_n_in & init_n_in;

	// ----------------------------------------
	// Field decoding
	// ----------------------------------------
	// Each compare has one home so the state walk and the
	// outputs cannot drift apart
	function is_start;
		input [3:0] code;
		begin
			is_start = (code == `LFD_START_READ) ||
				(code == `LFD_START_WRITE);
		end
	endfunction

	function is_write_code;
		input [3:0] code;
		begin
			is_write_code = (code == `LFD_START_WRITE);
		end
	endfunction

	function id_match;
		input [3:0] sel;
		input [3:0] strap;
		begin
			id_match = (sel == strap);
		end
	endfunction

	function size_is_byte;
		input [3:0] size;
		begin
			size_is_byte = (size == `LFD_SIZE_BYTE);
		end
	endfunction

	function last_addr_nibble;
		input [2:0] count;
		begin
			last_addr_nibble = (count == `LFD_ADDR_NIBBLES - 3'h1);
		end
	endfunction

	function [27:0] shift_nibble;
		input [27:0] acc;
		input [3:0] nib;
		begin
			// Shift left so the first nibble ends on top
			shift_nibble = {acc[23:0], nib};
		end
	endfunction

	function [2:0] count_up;
		input [2:0] count;
		begin
			count_up = count + 3'h1;
		end
	endfunction

	// ----------------------------------------
	// Preamble sequencing
	// ----------------------------------------
	// Start, select, seven address nibbles, then size: one field
	// per clock. A low strobe anywhere restarts the walk, which is
	// how the host abandons a cycle without any timeout here.
	always @* begin
		state_nxt = state_r;
		nib_cnt_nxt = nib_cnt_r;
		write_nxt = write_r;
		addr_nxt = addr_r;
		if (!frame_strobe_n_in) begin
			// Strobe still low: only the last start nibble counts
			if (is_start(muxed_nibble_lines_in)) begin
				state_nxt = ST_SEL;
				write_nxt = is_write_code(muxed_nibble_lines_in);
			end else begin
				state_nxt = ST_SKIP;
			end
		end else begin
			case (state_r)
			ST_IDLE: begin
				// Nothing to decode until the host strobes
				state_nxt = ST_IDLE;
			end
			ST_SEL: begin
				// One clock only: a select miss drops the cycle
				if (id_match(muxed_nibble_lines_in,
					id_strap_pins_in)) begin
					state_nxt = ST_ADDR;
					nib_cnt_nxt = 3'h0;
				end else begin
					state_nxt = ST_SKIP;
				end
			end
			ST_ADDR: begin
				addr_nxt = shift_nibble(addr_r, muxed_nibble_lines_in);
				nib_cnt_nxt = count_up(nib_cnt_r);
				if (last_addr_nibble(nib_cnt_r))
					state_nxt = ST_SIZE;
			end
			ST_SIZE: begin
				// Size closes the preamble; later phases are not ours
				state_nxt = ST_SKIP;
			end
			ST_SKIP: begin
				// Later phases are not ours; wait for next strobe
				state_nxt = ST_SKIP;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------
	// Preamble registers
	// ----------------------------------------
	always @(posedge sys_clk_in or negedge rst_all_n) begin
		if (!rst_all_n) begin
			state_r <= ST_IDLE;
			nib_cnt_r <= 3'h0;
			write_r <= 1'b0;
			addr_r <= 28'h0000000;
		end else begin
			state_r <= state_nxt;
			nib_cnt_r <= nib_cnt_nxt;
			write_r <= write_nxt;
			addr_r <= addr_nxt;
		end
	end

	// ----------------------------------------
	// Bus drivers
	// ----------------------------------------
	// Strobe wins over any later-phase drive request, so a host
	// abort always takes the bus back within one clock
	always @(posedge sys_clk_in or negedge rst_all_n) begin
		if (!rst_all_n) begin
			muxed_nibble_lines_out <= 4'h0;
			muxed_nibble_lines_oe_n_out <= 1'b1;
		end else if (!frame_strobe_n_in) begin
			muxed_nibble_lines_oe_n_out <= 1'b1;
			muxed_nibble_lines_out <= 4'h0;
		end else begin
			muxed_nibble_lines_oe_n_out <= ~drive_req_in;
			muxed_nibble_lines_out <= drive_data_in;
		end
	end

	// ----------------------------------------
	// Standby tracking
	// ----------------------------------------
	// Any strobe wakes the decoder; only a select miss sends it
	// back, so foreign cycle types keep it listening
	always @(posedge sys_clk_in or negedge rst_all_n) begin
		if (!rst_all_n)
			standby_out <= 1'b1;
		else if (!frame_strobe_n_in)
			standby_out <= 1'b0;
		else if (state_r == ST_SEL &&
			!id_match(muxed_nibble_lines_in, id_strap_pins_in))
			standby_out <= 1'b1;
	end

	// ----------------------------------------
	// Preamble result
	// ----------------------------------------
	// Address and direction move only on a finished size field,
	// so they stay valid for the later phases of that cycle
	always @(posedge sys_clk_in or negedge rst_all_n) begin
		if (!rst_all_n) begin
			cycle_valid_out <= 1'b0;
			cycle_write_out <= 1'b0;
			memory_address_field_out <= 28'h0000000;
			size_error_out <= 1'b0;
		end else begin
			cycle_valid_out <= 1'b0;
			size_error_out <= 1'b0;
			if (frame_strobe_n_in && state_r == ST_SIZE) begin
				memory_address_field_out <= addr_r;
				cycle_write_out <= write_r;
				if (size_is_byte(muxed_nibble_lines_in))
					cycle_valid_out <= 1'b1;
				else
					size_error_out <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Array mode
	// ----------------------------------------
	// No command path lives in this block, so only a reset
	// touches the mode; a later command stage would clear it
	always @(posedge sys_clk_in or negedge rst_all_n) begin
		if (!rst_all_n)
			read_array_mode_out <= 1'b1;
	end

	// ----------------------------------------
	// Reset side effects
	// ----------------------------------------
	// Busy as sampled on the last clock before init went low;
	// the sample freezes while init is held so the abort sticks
	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			busy_seen_r <= 1'b0;
		else if (init_n_in)
			busy_seen_r <= op_busy_in;
	end

	// Only init sets the flag and only power-on reset clears it
	// outright; an accepted write is taken as a fresh start
	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			op_abort_out <= 1'b0;
		else if (!init_n_in && busy_seen_r)
			op_abort_out <= 1'b1;
		else if (cycle_valid_out && cycle_write_out)
			op_abort_out <= 1'b0;
	end

	// ----------------------------------------
	// Wake and lock status
	// ----------------------------------------
	// Registered copies keep every output on a flop; the lock
	// view trails the lock bits by one clock
	always @(posedge sys_clk_in or negedge rst_all_n) begin
		if (!rst_all_n) begin
			cmd_write_ok_out <= 1'b0;
			sector_locked_out <= {SECTORS{1'b1}};
		end else begin
			cmd_write_ok_out <= wake_ok;
			sector_locked_out <= locks;
		end
	end

	// ----------------------------------------
	// Sub-blocks
	// ----------------------------------------
	// Unlocks before the wake interval are dropped like any
	// other command write
	lfd_wake_timer #(
		.WAKE_CYCLES(WAKE_CYCLES)
	) u_wake (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_all_n),
		.ready_out(wake_ok)
	);

	lfd_sector_lock #(
		.SECTORS(SECTORS)
	) u_lock (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_all_n),
		.unlock_in(unlock_in & wake_ok),
		.sector_in(unlock_sector_in),
		.locked_out(locks)
	);
endmodule // lfd_cycle_decode

// ===== verilog/lfd_map.vh
// Constants for the flash cycle preamble decoder
`ifndef LFD_MAP_VH
`define LFD_MAP_VH
// ----------------------------------------
// Cycle codes
// ----------------------------------------
`define LFD_START_READ 4'hD
`define LFD_START_WRITE 4'hE
`define LFD_SIZE_BYTE 4'h0
`define LFD_ADDR_NIBBLES 3'h7
// ----------------------------------------
// Timing
// ----------------------------------------
`define LFD_CLK_PERIOD_NS 20
`define LFD_WAKE_NS 1000
`define LFD_WAKE_CYCLES ((`LFD_WAKE_NS + `LFD_CLK_PERIOD_NS - 1) / `LFD_CLK_PERIOD_NS)
`endif

// ===== verilog/lfd_wake_timer.v
// Wake interval counter after reset release
`timescale 1ns/100ps
`include "lfd_map.vh"
module lfd_wake_timer #(
	parameter WAKE_CYCLES = `LFD_WAKE_CYCLES
) (
	input wire sys_clk_in, // System clock
	input wire rst_n_in, // Async reset, active low
	output reg ready_out // Command writes accepted
);
	reg [15:0] count_r;
	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_r <= 16'h0000;
			ready_out <= 1'b0;
		end else if (!ready_out) begin
			if (count_r >= WAKE_CYCLES[15:0] - 16'h0001)
				ready_out <= 1'b1;
			else
				count_r <= count_r + 16'h0001;
		end
	end
endmodule // lfd_wake_timer

// ===== verilog/lfd_sector_lock.v
// Sector lock bits, forced locked by any reset
`timescale 1ns/100ps
module lfd_sector_lock #(
	parameter SECTORS = 8
) (
	input wire sys_clk_in, // System clock
	input wire rst_n_in, // Async reset, active low
	input wire unlock_in, // Pulse: clear lock of one sector
	input wire [2:0] sector_in, // Sector to unlock
	output reg [SECTORS-1:0] locked_out // One bit per sector
);
	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			locked_out <= {SECTORS{1'b1}};
		else if (unlock_in)
			locked_out[sector_in] <= 1'b0;
	end
endmodule // lfd_sector_lock

// ===== tb/lfd_cycle_decode_properties.sv
// Concurrent checks on the preamble decoder ports
`timescale 1ns/100ps
module lfd_cycle_decode_props #(
	parameter SECTORS = 8
) (
	input wire sys_clk_in, // Bus clock
	input wire rst_n_in, // Reset, active low
	input wire init_n_in, // Second reset, active low
	input wire frame_strobe_n_in, // Frame strobe
	input wire [3:0] muxed_nibble_lines_in, // Nibble in
	input wire [3:0] id_strap_pins_in, // Strapped id
	input wire muxed_nibble_lines_oe_n_out, // Drive enable
	input wire cycle_valid_out, // Accept pulse
	input wire cycle_write_out, // Direction
	input wire [27:0] memory_address_field_out, // Address
	input wire size_error_out, // Size pulse
	input wire standby_out, // Standby
	input wire read_array_mode_out, // Array mode
	input wire cmd_write_ok_out, // Wake elapsed
	input wire [SECTORS-1:0] sector_locked_out // Locks
);
	wire go = rst_n_in && init_n_in;
	reg [27:0] sh_r;
	// Last seven nibbles seen, for the address comparison
	always @(posedge sys_clk_in) begin
		sh_r <= {sh_r[23:0], muxed_nibble_lines_in};
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!go);
	sequence s_pre(logic [3:0] c);
		!frame_strobe_n_in && muxed_nibble_lines_in == c ##1
		frame_strobe_n_in && muxed_nibble_lines_in == id_strap_pins_in
		##1 frame_strobe_n_in [*7] ##1 frame_strobe_n_in;
	endsequence
	property p_acc(logic [3:0] c, logic w);
		s_pre(c) ##0 muxed_nibble_lines_in == 4'h0
		|=> cycle_valid_out && cycle_write_out == w;
	endproperty
	a_read_accept: assert property (p_acc(4'hD, 1'b0))
		else $error("read preamble not accepted");
	a_write_accept: assert property (p_acc(4'hE, 1'b1))
		else $error("write preamble not accepted");
	a_addr_order: assert property (
		s_pre(4'hD) ##0 muxed_nibble_lines_in == 4'h0
		|=> memory_address_field_out == $past(sh_r))
		else $error("address assembled wrongly");
	a_size_check: assert property (
		s_pre(4'hE) ##0 muxed_nibble_lines_in != 4'h0
		|=> size_error_out && !cycle_valid_out)
		else $error("size field not flagged");
	a_bad_start: assert property (
		!frame_strobe_n_in && muxed_nibble_lines_in != 4'hD &&
		muxed_nibble_lines_in != 4'hE ##1 frame_strobe_n_in [*8]
		##1 frame_strobe_n_in |=> !cycle_valid_out && !size_error_out)
		else $error("foreign start code decoded");
	a_id_mismatch: assert property (
		!frame_strobe_n_in && muxed_nibble_lines_in == 4'hD ##1
		frame_strobe_n_in && muxed_nibble_lines_in != id_strap_pins_in
		|=> standby_out ##8 !cycle_valid_out)
		else $error("unselected cycle handled");
	a_bus_release: assert property (
		!frame_strobe_n_in |=> muxed_nibble_lines_oe_n_out)
		else $error("bus not released after strobe");
	a_wake_listen: assert property (
		!frame_strobe_n_in |=> !standby_out)
		else $error("standby kept after strobe");
	a_read_mode: assert property (read_array_mode_out)
		else $error("array mode lost");
	a_reset_state: assert property (disable iff (1'b0)
		!go |-> muxed_nibble_lines_oe_n_out && standby_out &&
		!cmd_write_ok_out && &sector_locked_out)
		else $error("reset state wrong");
endmodule // lfd_cycle_decode_props
bind lfd_cycle_decode lfd_cycle_decode_props #(.SECTORS(SECTORS)) u_props (.*);

// ===== tb/lfd_host_model.sv
// Host model that drives preambles onto the nibble bus
`timescale 1ns/100ps
module lfd_host_model (
	input wire sys_clk_in, // Bus clock
	output reg frame_strobe_n_out, // Frame strobe
	output reg [3:0] muxed_nibble_lines_out // Nibble to device
);
	integer i;
	initial begin
		frame_strobe_n_out = 1'b1;
		muxed_nibble_lines_out = 4'hF;
	end
	task step(input s, input [3:0] v);
		@(posedge sys_clk_in);
		#2;
		frame_strobe_n_out = s;
		muxed_nibble_lines_out = v;
	endtask
	// Hold puts stale write codes under a long strobe first
	task send(input [3:0] code, input [3:0] id, input [27:0] adr,
		input [3:0] size, input integer hold);
		for (i = 0; i < hold; i = i + 1)
			step(1'b0, 4'hE);
		step(1'b0, code);
		step(1'b1, id);
		for (i = 6; i >= 0; i = i - 1)
			step(1'b1, adr[i*4 +: 4]);
		step(1'b1, size);
		// Released bus shows the inverse, never a held value
		step(1'b1, ~size);
	endtask
endmodule // lfd_host_model

// ===== tb/test_lfd_cycle_decode.sv
// Self-checking bench for the preamble decoder
`timescale 1ns/100ps
module test_lfd_cycle_decode;
	reg clk = 1'b0;
	reg rst_n = 1'b1;
	reg init_n = 1'b1;
	reg drv = 1'b0;
	reg busy = 1'b0;
	reg unl = 1'b0;
	wire strobe_n, oe_n, valid, wr, serr, stby, rd_arr, abort, wake_ok;
	wire [3:0] nib_in, nib_out;
	wire [27:0] addr;
	wire [7:0] locks;
	integer mismatches = 0;
	integer comparisons = 0;
	integer cycles = 0;
	always #10 clk = ~clk;
	lfd_host_model host (.sys_clk_in(clk), .frame_strobe_n_out(strobe_n),
		.muxed_nibble_lines_out(nib_in));
	lfd_cycle_decode #(.WAKE_CYCLES(4)) dut (.sys_clk_in(clk),
		.rst_n_in(rst_n), .init_n_in(init_n), .frame_strobe_n_in(strobe_n),
		.muxed_nibble_lines_in(nib_in), .id_strap_pins_in(4'h5),
		.drive_req_in(drv), .drive_data_in(4'h9), .op_busy_in(busy),
		.unlock_in(unl), .unlock_sector_in(3'h3),
		.muxed_nibble_lines_out(nib_out),
		.muxed_nibble_lines_oe_n_out(oe_n), .cycle_valid_out(valid),
		.cycle_write_out(wr), .memory_address_field_out(addr),
		.size_error_out(serr), .standby_out(stby),
		.read_array_mode_out(rd_arr), .op_abort_out(abort),
		.cmd_write_ok_out(wake_ok), .sector_locked_out(locks));
	task chk(input [31:0] got, input [31:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Generous ceiling; the whole sequence needs about 110 cycles
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 2000) begin
			mismatches = mismatches + 1;
			complete_run;
		end
	end
	task t_boot;
		chk({oe_n, stby, rd_arr, wake_ok, locks}, 12'hEFF);
		@(posedge clk);
		#2 rst_n = 1'b1;
		unl = 1'b1;
		@(posedge clk);
		#2 unl = 1'b0;
		chk(wake_ok, 0);
		repeat (3) @(posedge clk);
		#2 chk({wake_ok, locks}, 9'h0FF);
		@(posedge clk);
		#2 chk(wake_ok, 1);
	endtask
	task t_lock;
		unl = 1'b1;
		@(posedge clk);
		#2 unl = 1'b0;
		@(posedge clk);
		#2 chk(locks, 8'hF7);
		busy = 1'b1;
		@(posedge clk);
		#2 init_n = 1'b0;
		@(posedge clk);
		#2 chk({abort, oe_n, locks}, 10'h3FF);
		init_n = 1'b1;
		busy = 1'b0;
		@(posedge clk);
		#2 chk(rd_arr, 1);
	endtask
	task t_read;
		host.send(4'hD, 4'h5, 28'hA5C3E71, 4'h0, 0);
		chk({valid, wr, serr, stby}, 4'h8);
		chk(addr, 28'hA5C3E71);
	endtask
	task t_write;
		host.send(4'hE, 4'h5, 28'h0123456, 4'h0, 0);
		chk({valid, wr, serr, abort}, 4'hD);
		chk(addr, 28'h0123456);
		@(posedge clk);
		#2 chk({valid, abort}, 2'h0);
	endtask
	task t_hold;
		host.send(4'hD, 4'h5, 28'hFEDCBA9, 4'h0, 2);
		chk({valid, wr, addr}, {2'h2, 28'hFEDCBA9});
	endtask
	task t_bad;
		host.send(4'h0, 4'h5, 28'h1111111, 4'h0, 0);
		chk({valid, serr, addr}, {2'h0, 28'hFEDCBA9});
	endtask
	task t_other;
		host.send(4'hD, 4'hA, 28'h2222222, 4'h0, 0);
		chk({valid, serr, stby}, 3'h1);
	endtask
	task t_size;
		host.send(4'hE, 4'h5, 28'hFFFFFFF, 4'h3, 0);
		chk({valid, serr}, 2'h1);
	endtask
	task t_drive;
		drv = 1'b1;
		@(posedge clk);
		#2 chk({oe_n, nib_out}, 5'h09);
		host.send(4'hD, 4'h5, 28'h0000001, 4'h0, 0);
		drv = 1'b0;
		chk(valid, 1);
	endtask
	initial begin
		#1 rst_n = 1'b0;
		repeat (16) @(posedge clk);
		#2;
		t_boot;
		t_lock;
		t_read;
		t_write;
		t_hold;
		t_bad;
		t_other;
		t_size;
		t_drive;
		complete_run;
	end
endmodule // test_lfd_cycle_decode
